// [design/dag_pkg.sv]
// Shared constants and types of the data address generator
package dag_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int PC_W = 11;
  localparam int NREG = 32;
  localparam int OFS_W = 7;
  // ==========================================================
  // Data space map
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] SRAM_END = 16'h00DF;
  // ==========================================================
  // Pointer pairs, low byte register index
  localparam logic [4:0] PTR_A_LO = 5'h1A;
  localparam logic [4:0] PTR_B_LO = 5'h1C;
  localparam logic [4:0] PTR_C_LO = 5'h1E;
  // ==========================================================
  // Reset values
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [7:0] REG_RST = 8'h00;
  // ==========================================================
  // Timing at 10 MHz
  localparam int CLK_NS = 100;
  localparam int SRAM_ACC_CYC = 2;
  localparam int ALU_CYC = 1;
  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {REG_SPACE, IO_SPACE, SRAM_SPACE, NO_SPACE} dag_region_e;
  typedef enum logic [2:0] {AM_DIRECT, AM_IO, AM_DISP, AM_IND, AM_PREDEC, AM_POSTINC} dag_amode_e;
  typedef enum logic [2:0] {OK_NOP, OK_ALU, OK_LOAD, OK_STORE, OK_CONST, OK_IJUMP, OK_RJUMP} dag_opkind_e;
  typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV} dag_alu_e;
  typedef enum logic [1:0] {PTR_A, PTR_B, PTR_C} dag_ptr_e;
endpackage

// [design/dag_dec_if.sv]
// Carrier between address former and data space decoder
`timescale 1ns/1ns
interface dag_dec_if;
  import dag_pkg::*;
  logic [15:0] addr;
  dag_region_e region;
  logic [6:0] offset;
  modport req (output addr, input region, input offset);
  modport dec (input addr, output region, output offset);
endinterface

// [design/dag_decoder.sv]
// Data space decoder: register file, I/O, SRAM, unmapped
`timescale 1ns/1ns
module dag_decoder
  import dag_pkg::*;
(
  // Decode carrier
  dag_dec_if.dec d
);
  import dag_pkg::*;
  logic [15:0] rel;

  // ==========================================================
  // Region select
  always_comb begin
    rel = 16'h0000;
    if (d.addr < IO_BASE) begin
      d.region = REG_SPACE;
      rel = d.addr;
    end else if (d.addr < SRAM_BASE) begin
      d.region = IO_SPACE;
      rel = d.addr - IO_BASE;
    end else if (d.addr <= SRAM_END) begin
      d.region = SRAM_SPACE;
      rel = d.addr - SRAM_BASE;
    end else begin
      // Above the SRAM nothing answers
      d.region = NO_SPACE;
    end
    d.offset = rel[6:0];
  end
endmodule

// [design/dag_regfile.sv]
// Working register file of 32 bytes with pointer pairs
`timescale 1ns/1ns
module dag_regfile
  import dag_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Read ports
  input wire logic [4:0] rd_a_idx_i,
  input wire logic [4:0] rd_b_idx_i,
  input wire logic [4:0] rd_c_idx_i,
  output logic [7:0] rd_a_o,
  output logic [7:0] rd_b_o,
  output logic [7:0] rd_c_o,
  // Pointer pairs
  output logic [15:0] ptr_a_o,
  output logic [15:0] ptr_b_o,
  output logic [15:0] ptr_c_o,
  // Data write
  input wire logic we_i,
  input wire logic [4:0] widx_i,
  input wire logic [7:0] wdata_i,
  // Pointer write-back
  input wire logic pwe_i,
  input wire dag_pkg::dag_ptr_e psel_i,
  input wire logic [15:0] pval_i
);
  import dag_pkg::*;
  logic [7:0] regs_r [NREG];
  logic [4:0] plo;

  always_comb begin
    unique case (psel_i)
      PTR_A: plo = PTR_A_LO;
      PTR_B: plo = PTR_B_LO;
      default: plo = PTR_C_LO;
    endcase
  end

  // ==========================================================
  // Storage; a data write wins over a pointer write-back
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        regs_r[i] <= REG_RST;
      end else if (we_i && widx_i == 5'(i)) begin
        regs_r[i] <= wdata_i;
      end else if (pwe_i && plo == 5'(i)) begin
        regs_r[i] <= pval_i[7:0];
      end else if (pwe_i && (plo + 5'h01) == 5'(i)) begin
        regs_r[i] <= pval_i[15:8];
      end
    end
  end

  assign rd_a_o = regs_r[rd_a_idx_i];
  assign rd_b_o = regs_r[rd_b_idx_i];
  assign rd_c_o = regs_r[rd_c_idx_i];
  // Lower register of each pair is the low byte
  assign ptr_a_o = {regs_r[PTR_A_LO + 5'h01], regs_r[PTR_A_LO]};
  assign ptr_b_o = {regs_r[PTR_B_LO + 5'h01], regs_r[PTR_B_LO]};
  assign ptr_c_o = {regs_r[PTR_C_LO + 5'h01], regs_r[PTR_C_LO]};

  rf_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    we_i |=> regs_r[$past(widx_i)] == $past(wdata_i))
    else $error("register write lost");
endmodule

// [design/dag_top.sv]
// Data address generator: operand addressing, data space access, program flow
`timescale 1ns/1ns
module dag_top
  import dag_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Operation request
  input wire logic op_valid_i,
  input wire dag_pkg::dag_opkind_e op_kind_i,
  input wire dag_pkg::dag_amode_e amode_i,
  input wire dag_pkg::dag_ptr_e ptr_sel_i,
  input wire dag_pkg::dag_alu_e alu_func_i,
  input wire logic [4:0] dest_reg_index_i,
  input wire logic [4:0] src_reg_index_i,
  input wire logic [5:0] disp_i,
  input wire logic [5:0] io_num_i,
  input wire logic [15:0] direct_addr_i,
  input wire logic [10:0] rel_off_i,
  output logic busy_o,
  // Program fetch
  output logic [10:0] prog_addr_o,
  input wire logic [15:0] prog_data_i,
  output logic [15:0] instr_o,
  output logic instr_valid_o,
  // Constant read port of program memory
  output logic [14:0] const_addr_o,
  input wire logic [15:0] const_data_i,
  // I/O space
  output logic [5:0] io_addr_o,
  output logic io_re_o,
  output logic io_we_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i,
  // Internal data SRAM
  output logic [6:0] sram_addr_o,
  output logic sram_re_o,
  output logic sram_we_o,
  output logic [7:0] sram_wdata_o,
  input wire logic [7:0] sram_rdata_i
);
  import dag_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_MEM} dag_state_e;

  dag_state_e state_r;
  dag_region_e region_r;
  dag_opkind_e kind_r;
  logic [6:0] ofs_r;
  logic [4:0] dest_r;
  logic [7:0] st_data_r;
  logic byte_hi_r;
  logic [10:0] pc_r;
  logic [15:0] instr_r;
  logic instr_valid_r;

  logic [7:0] rd_a, rd_b, rd_c;
  logic [15:0] ptr_a, ptr_b, ptr_c, ptr_cur, ea, ptr_wb;
  logic accept, mem_op, jump, adv, ptr_we;
  logic rf_we;
  logic [4:0] rf_widx;
  logic [7:0] rf_wdata, alu_res, ld_data;

  dag_dec_if dec ();

  // ==========================================================
  // Submodules
  dag_decoder u_dec (
    .d (dec)
  );

  dag_regfile u_rf (
    .sys_clk_i (sys_clk_i),
    .rst_i (rst_i),
    .rd_a_idx_i (dest_reg_index_i),
    .rd_b_idx_i (src_reg_index_i),
    .rd_c_idx_i (ofs_r[4:0]),
    .rd_a_o (rd_a),
    .rd_b_o (rd_b),
    .rd_c_o (rd_c),
    .ptr_a_o (ptr_a),
    .ptr_b_o (ptr_b),
    .ptr_c_o (ptr_c),
    .we_i (rf_we),
    .widx_i (rf_widx),
    .wdata_i (rf_wdata),
    .pwe_i (ptr_we),
    .psel_i (ptr_sel_i),
    .pval_i (ptr_wb)
  );

  // ==========================================================
  // Request acceptance
  assign accept = op_valid_i && state_r == ST_IDLE && instr_valid_r;
  assign mem_op = op_kind_i == OK_LOAD || op_kind_i == OK_STORE || op_kind_i == OK_CONST;
  assign jump = op_kind_i == OK_IJUMP || op_kind_i == OK_RJUMP;

  // ==========================================================
  // Operand address forming
  always_comb begin
    unique case (ptr_sel_i)
      PTR_A: ptr_cur = ptr_a;
      PTR_B: ptr_cur = ptr_b;
      default: ptr_cur = ptr_c;
    endcase
  end

  always_comb begin
    unique case (amode_i)
      AM_DIRECT: ea = direct_addr_i;
      AM_IO: ea = IO_BASE + {10'h000, io_num_i};
      // Only ptr_b and ptr_c carry a displacement; wraps at 16 bits
      AM_DISP: ea = ((ptr_sel_i == PTR_C) ? ptr_c : ptr_b) + {10'h000, disp_i};
      AM_IND: ea = ptr_cur;
      AM_PREDEC: ea = ptr_cur - 16'h0001;
      default: ea = ptr_cur;
    endcase
  end

  assign dec.addr = ea;

  // Write-back of the moved pointer, modulo 2^16
  assign ptr_wb = (amode_i == AM_PREDEC) ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001;
  assign ptr_we = accept && (op_kind_i == OK_LOAD || op_kind_i == OK_STORE)
    && (amode_i == AM_PREDEC || amode_i == AM_POSTINC);

  // ==========================================================
  // Register ALU, done within the accepting cycle
  always_comb begin
    unique case (alu_func_i)
      ALU_ADD: alu_res = rd_a + rd_b;
      ALU_SUB: alu_res = rd_a - rd_b;
      ALU_AND: alu_res = rd_a & rd_b;
      ALU_OR: alu_res = rd_a | rd_b;
      ALU_XOR: alu_res = rd_a ^ rd_b;
      default: alu_res = rd_b;
    endcase
  end

  always_comb begin
    unique case (region_r)
      REG_SPACE: ld_data = rd_c;
      IO_SPACE: ld_data = io_rdata_i;
      SRAM_SPACE: ld_data = sram_rdata_i;
      default: ld_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Register file write select
  always_comb begin
    rf_we = 1'b0;
    rf_widx = dest_reg_index_i;
    rf_wdata = alu_res;
    if (accept && op_kind_i == OK_ALU) begin
      rf_we = 1'b1;
    end else if (state_r == ST_MEM && kind_r == OK_LOAD) begin
      rf_we = 1'b1;
      rf_widx = dest_r;
      rf_wdata = ld_data;
    end else if (state_r == ST_MEM && kind_r == OK_CONST) begin
      rf_we = 1'b1;
      rf_widx = dest_r;
      rf_wdata = byte_hi_r ? const_data_i[15:8] : const_data_i[7:0];
    end else if (state_r == ST_MEM && kind_r == OK_STORE && region_r == REG_SPACE) begin
      rf_we = 1'b1;
      rf_widx = ofs_r[4:0];
      rf_wdata = st_data_r;
    end
  end

  // ==========================================================
  // Access sequencer: memory operations hold two cycles
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else if (accept && mem_op) begin
      state_r <= ST_MEM;
    end else begin
      state_r <= ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      region_r <= NO_SPACE;
      kind_r <= OK_NOP;
      ofs_r <= 7'h00;
      dest_r <= 5'h00;
      st_data_r <= 8'h00;
      byte_hi_r <= 1'b0;
    end else if (accept && mem_op) begin
      region_r <= dec.region;
      kind_r <= op_kind_i;
      ofs_r <= dec.offset;
      dest_r <= dest_reg_index_i;
      st_data_r <= rd_b;
      byte_hi_r <= ptr_c[0];
    end
  end

  assign busy_o = (state_r == ST_MEM);

  // ==========================================================
  // Strobes to I/O, SRAM and constant port
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      io_addr_o <= 6'h00;
      io_re_o <= 1'b0;
      io_we_o <= 1'b0;
      io_wdata_o <= 8'h00;
      sram_addr_o <= 7'h00;
      sram_re_o <= 1'b0;
      sram_we_o <= 1'b0;
      sram_wdata_o <= 8'h00;
      const_addr_o <= 15'h0000;
    end else begin
      io_re_o <= 1'b0;
      io_we_o <= 1'b0;
      sram_re_o <= 1'b0;
      sram_we_o <= 1'b0;
      if (accept && (op_kind_i == OK_LOAD || op_kind_i == OK_STORE)) begin
        // Unmapped addresses raise no strobe at all
        if (dec.region == IO_SPACE) begin
          io_addr_o <= dec.offset[5:0];
          io_re_o <= op_kind_i == OK_LOAD;
          io_we_o <= op_kind_i == OK_STORE;
          io_wdata_o <= rd_b;
        end else if (dec.region == SRAM_SPACE) begin
          sram_addr_o <= dec.offset;
          sram_re_o <= op_kind_i == OK_LOAD;
          sram_we_o <= op_kind_i == OK_STORE;
          sram_wdata_o <= rd_b;
        end
      end
      if (accept && op_kind_i == OK_CONST) begin
        const_addr_o <= ptr_c[15:1];
      end
    end
  end

  // ==========================================================
  // Program counter and prefetch
  assign adv = !instr_valid_r || state_r == ST_MEM || (accept && !mem_op && !jump);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pc_r <= PC_RST;
      instr_r <= 16'h0000;
      instr_valid_r <= 1'b0;
    end else if (accept && op_kind_i == OK_IJUMP) begin
      pc_r <= ptr_c[10:0];
      instr_valid_r <= 1'b0;
    end else if (accept && op_kind_i == OK_RJUMP) begin
      // pc_r already leads the executing word by one
      pc_r <= pc_r + rel_off_i;
      instr_valid_r <= 1'b0;
    end else if (adv) begin
      pc_r <= pc_r + 11'h001;
      instr_r <= prog_data_i;
      instr_valid_r <= 1'b1;
    end
  end

  assign prog_addr_o = pc_r;
  assign instr_o = instr_r;
  assign instr_valid_o = instr_valid_r;

  // ==========================================================
  // Checks
  sram_two_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && (op_kind_i == OK_LOAD || op_kind_i == OK_STORE) && dec.region == SRAM_SPACE)
    |=> (sram_re_o || sram_we_o) && busy_o ##1 !(sram_re_o || sram_we_o) && !busy_o)
    else $error("sram access not two cycles");

  map_split_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (dec.addr >= SRAM_BASE && dec.addr <= SRAM_END) == (dec.region == SRAM_SPACE))
    else $error("sram window decoded wrong");

  unmapped_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && mem_op && dec.region == NO_SPACE)
    |=> !(sram_re_o || sram_we_o || io_re_o || io_we_o) && (kind_r != OK_LOAD || rf_wdata == 8'h00))
    else $error("unmapped access not ignored");

  predec_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && op_kind_i == OK_LOAD && amode_i == AM_PREDEC && dec.region == SRAM_SPACE)
    |=> sram_addr_o == 7'($past(ptr_cur) - 16'h0001 - SRAM_BASE))
    else $error("pre-decrement address wrong");

  postinc_wb_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && op_kind_i == OK_STORE && amode_i == AM_POSTINC && ptr_sel_i == PTR_A)
    |=> ptr_a == $past(ptr_cur) + 16'h0001)
    else $error("post-increment write-back wrong");

  rel_jump_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && op_kind_i == OK_RJUMP)
    |=> pc_r == $past(pc_r) + $past(rel_off_i) && !instr_valid_o)
    else $error("relative target wrong");

  ind_jump_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && op_kind_i == OK_IJUMP) |=> pc_r == 11'($past(ptr_c)))
    else $error("indirect target wrong");

  const_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && op_kind_i == OK_CONST) |=> const_addr_o == 15'($past(ptr_c) >> 1) && busy_o)
    else $error("constant word address wrong");

  fetch_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && op_kind_i == OK_ALU) |=> pc_r == $past(pc_r) + 11'h001 && instr_valid_o && !busy_o)
    else $error("fetch did not overlap execute");
endmodule

// [dv/dag_mem_model.sv]
// Behavioural program flash, I/O registers and data SRAM for the address generator
`timescale 1ns/1ns
module dag_mem_model (
  // Clock
  input wire logic sys_clk_i,
  // Program fetch and constant port
  input wire logic [10:0] prog_addr_i,
  output logic [15:0] prog_data_o,
  input wire logic [14:0] const_addr_i,
  output logic [15:0] const_data_o,
  // I/O space
  input wire logic [5:0] io_addr_i,
  input wire logic io_re_i,
  input wire logic io_we_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Data SRAM
  input wire logic [6:0] sram_addr_i,
  input wire logic sram_re_i,
  input wire logic sram_we_i,
  input wire logic [7:0] sram_wdata_i,
  output logic [7:0] sram_rdata_o
);
  logic [15:0] prog [0:2047];
  logic [7:0] sram [0:127];
  logic [7:0] io [0:63];
  logic [7:0] churn_r;
  // ==========================================================
  // Contents
  initial begin
    churn_r = 8'h00;
    for (int i = 0; i < 2048; i++) begin
      prog[i] = 16'(i * 40503 + 7);
    end
    // Every SRAM byte is itself a mapped data address
    for (int i = 0; i < 128; i++) begin
      sram[i] = 8'h60 + 8'(i);
    end
    for (int i = 0; i < 64; i++) begin
      io[i] = 8'(i * 7 + 1);
    end
  end
  // ==========================================================
  // Read and write
  assign prog_data_o = prog[prog_addr_i];
  assign const_data_o = prog[const_addr_i[10:0]];
  // Released read bus moves every cycle, so a late sample is caught
  assign io_rdata_o = io_re_i ? io[io_addr_i] : churn_r;
  assign sram_rdata_o = sram_re_i ? sram[sram_addr_i] : ~churn_r;
  always @(posedge sys_clk_i) begin
    churn_r <= churn_r + 8'h5B;
    if (io_we_i) begin
      io[io_addr_i] <= io_wdata_i;
    end
    if (sram_we_i) begin
      sram[sram_addr_i] <= sram_wdata_i;
    end
  end
endmodule

// [dv/dag_top_test.sv]
// Self-checking bench for the data address generator against a reference model
`timescale 1ns/1ns
module dag_top_test;
  import dag_pkg::*;
  // ==========================================================
  // Signals and model state
  logic sys_clk_i, rst_i, op_valid_i, busy_o, instr_valid_o;
  dag_opkind_e op_kind_i;
  dag_amode_e amode_i;
  dag_ptr_e ptr_sel_i;
  dag_alu_e alu_func_i;
  logic [4:0] dest_reg_index_i, src_reg_index_i;
  logic [5:0] disp_i, io_num_i, io_addr_o;
  logic [15:0] direct_addr_i, prog_data_i, instr_o, const_data_i;
  logic [10:0] rel_off_i, prog_addr_o;
  logic [14:0] const_addr_o;
  logic io_re_o, io_we_o, sram_re_o, sram_we_o;
  logic [7:0] io_wdata_o, io_rdata_i, sram_wdata_o, sram_rdata_i;
  logic [6:0] sram_addr_o;
  logic [7:0] regs [0:31];
  logic [7:0] sram_m [0:127];
  logic [7:0] io_m [0:63];
  int err_count, samples_checked;
  integer seed;
  dag_top dag_top_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_kind_i(op_kind_i), .amode_i(amode_i),
    .ptr_sel_i(ptr_sel_i), .alu_func_i(alu_func_i), .dest_reg_index_i(dest_reg_index_i),
    .src_reg_index_i(src_reg_index_i), .disp_i(disp_i), .io_num_i(io_num_i), .direct_addr_i(direct_addr_i),
    .rel_off_i(rel_off_i), .busy_o(busy_o), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
    .instr_o(instr_o), .instr_valid_o(instr_valid_o), .const_addr_o(const_addr_o), .const_data_i(const_data_i),
    .io_addr_o(io_addr_o), .io_re_o(io_re_o), .io_we_o(io_we_o), .io_wdata_o(io_wdata_o),
    .io_rdata_i(io_rdata_i), .sram_addr_o(sram_addr_o), .sram_re_o(sram_re_o), .sram_we_o(sram_we_o),
    .sram_wdata_o(sram_wdata_o), .sram_rdata_i(sram_rdata_i));
  dag_mem_model dag_mem_model_i (
    .sys_clk_i(sys_clk_i), .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i), .const_addr_i(const_addr_o),
    .const_data_o(const_data_i), .io_addr_i(io_addr_o), .io_re_i(io_re_o), .io_we_i(io_we_o),
    .io_wdata_i(io_wdata_o), .io_rdata_o(io_rdata_i), .sram_addr_i(sram_addr_o), .sram_re_i(sram_re_o),
    .sram_we_i(sram_we_o), .sram_wdata_i(sram_wdata_o), .sram_rdata_o(sram_rdata_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #(CLK_NS / 2) sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] ptr(input logic [4:0] lo);
    return {regs[lo + 5'd1], regs[lo]};
  endfunction
  function automatic logic [7:0] alu(input dag_alu_e f, input logic [7:0] a, input logic [7:0] b);
    case (f)
      ALU_ADD: return a + b;
      ALU_SUB: return a - b;
      ALU_AND: return a & b;
      ALU_OR: return a | b;
      ALU_XOR: return a ^ b;
      default: return b;
    endcase
  endfunction
  // Ends at the edge that takes the request; pa is the fetch address seen just before it
  task automatic wait_accept(output logic [10:0] pa);
    int n;
    bit ok;
    n = 0;
    ok = 0;
    while (!ok) begin
      @(negedge sys_clk_i);
      ok = (busy_o === 1'b0) && (instr_valid_o === 1'b1);
      pa = prog_addr_o;
      if (ok) begin
        // Every earlier result must already sit in the register file
        for (int i = 0; i < 32; i++) check(dag_top_i.u_rf.regs_r[i], regs[i]);
      end
      if (instr_valid_o === 1'b1) check(instr_o, dag_mem_model_i.prog[prog_addr_o - 11'd1]);
      @(posedge sys_clk_i);
      n++;
      if (n > 20) begin
        err_count++;
        summarize();
      end
    end
  endtask
  // ==========================================================
  // One operation, driven and predicted
  task automatic run_op(input dag_opkind_e k, input dag_amode_e m, input dag_ptr_e p, input dag_alu_e f,
                        input logic [4:0] d, input logic [4:0] s, input logic [5:0] dsp, input logic [5:0] ion,
                        input logic [15:0] da, input logic [10:0] ro);
    logic [10:0] pa;
    logic [10:0] t;
    logic [4:0] lo;
    logic [15:0] a;
    logic [15:0] w;
    logic [7:0] v;
    bit ld, st, inio, insr;
    op_valid_i <= 1'b1;
    op_kind_i <= k;
    amode_i <= m;
    ptr_sel_i <= p;
    alu_func_i <= f;
    dest_reg_index_i <= d;
    src_reg_index_i <= s;
    disp_i <= dsp;
    io_num_i <= ion;
    direct_addr_i <= da;
    rel_off_i <= ro;
    wait_accept(pa);
    ld = (k == OK_LOAD);
    st = (k == OK_STORE);
    lo = (p == PTR_A) ? PTR_A_LO : (p == PTR_B) ? PTR_B_LO : PTR_C_LO;
    v = regs[s];
    a = ptr(PTR_C_LO);
    if (k == OK_ALU) begin
      regs[d] = alu(f, regs[d], regs[s]);
    end else if (k == OK_RJUMP || k == OK_IJUMP) begin
      t = (k == OK_RJUMP) ? pa + ro : a[10:0];
      @(negedge sys_clk_i);
      check(prog_addr_o, t);
      @(posedge sys_clk_i);
    end else if (k == OK_CONST) begin
      @(negedge sys_clk_i);
      check(const_addr_o, a[15:1]);
      w = dag_mem_model_i.prog[a[11:1]];
      regs[d] = a[0] ? w[15:8] : w[7:0];
      @(posedge sys_clk_i);
    end else if (ld || st) begin
      case (m)
        AM_DIRECT: a = da;
        AM_IO: a = IO_BASE + ion;
        AM_DISP: a = ptr((p == PTR_C) ? PTR_C_LO : PTR_B_LO) + dsp;
        AM_PREDEC: a = ptr(lo) - 16'd1;
        default: a = ptr(lo);
      endcase
      if (m == AM_PREDEC || m == AM_POSTINC) begin
        w = (m == AM_PREDEC) ? a : a + 16'd1;
        regs[lo] = w[7:0];
        regs[lo + 5'd1] = w[15:8];
      end
      inio = (a >= IO_BASE) && (a < SRAM_BASE);
      insr = (a >= SRAM_BASE) && (a <= SRAM_END);
      @(negedge sys_clk_i);
      check(busy_o, 1'b1);
      check({sram_re_o, sram_we_o, io_re_o, io_we_o}, {insr & ld, insr & st, inio & ld, inio & st});
      if (insr) check(sram_addr_o, a - SRAM_BASE);
      if (inio) check(io_addr_o, a - IO_BASE);
      if (st && insr) check(sram_wdata_o, v);
      if (st && inio) check(io_wdata_o, v);
      if (ld) begin
        regs[d] = (a < IO_BASE) ? regs[a[4:0]] : inio ? io_m[a - IO_BASE] : insr ? sram_m[a - SRAM_BASE] : 8'h00;
      end else if (a < IO_BASE) begin
        regs[a[4:0]] = v;
      end else if (inio) begin
        io_m[a - IO_BASE] = v;
      end else if (insr) begin
        sram_m[a - SRAM_BASE] = v;
      end
      @(posedge sys_clk_i);
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r1, r2;
    dag_opkind_e k;
    dag_amode_e m;
    logic [4:0] d, s;
    logic [15:0] da;
    seed = 32'h938DEC0F;
    err_count = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_kind_i = OK_NOP;
    amode_i = AM_DIRECT;
    ptr_sel_i = PTR_A;
    alu_func_i = ALU_ADD;
    dest_reg_index_i = 5'h00;
    src_reg_index_i = 5'h00;
    disp_i = 6'h00;
    io_num_i = 6'h00;
    direct_addr_i = 16'h0000;
    rel_off_i = 11'h000;
    for (int i = 0; i < 32; i++) regs[i] = REG_RST;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    check({busy_o, sram_re_o, sram_we_o, io_re_o, io_we_o, prog_addr_o}, 16'h0000);
    @(negedge sys_clk_i);
    check({instr_valid_o, prog_addr_o}, {1'b1, 11'h001});
    for (int i = 0; i < 128; i++) sram_m[i] = dag_mem_model_i.sram[i];
    for (int i = 0; i < 64; i++) io_m[i] = dag_mem_model_i.io[i];
    @(posedge sys_clk_i);
    // Pointer wraps below zero and back above the top
    run_op(OK_LOAD, AM_PREDEC, PTR_A, ALU_ADD, 5'h03, 5'h00, 6'h00, 6'h00, 16'h0000, 11'h000);
    run_op(OK_LOAD, AM_POSTINC, PTR_A, ALU_ADD, 5'h04, 5'h00, 6'h00, 6'h00, 16'h0000, 11'h000);
    for (int i = 0; i < 800; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      k = (r1[2:0] == 3'd7) ? OK_LOAD : dag_opkind_e'(r1[2:0]);
      m = (r1[5:3] > 3'd5) ? AM_IND : dag_amode_e'(r1[5:3]);
      d = r1[15:11];
      s = r1[20:16];
      da = (r2[11:8] == 4'h0) ? r2[31:16] : {8'h00, r2[7:0]};
      // Pointer high bytes mostly zero, so indirect modes land in the map
      if (k == OK_LOAD && d > 5'd26 && d[0] && r2[12]) begin
        m = AM_DIRECT;
        da = 16'hFFFF;
      end
      if (k == OK_STORE && s > 5'd25) s = s - 5'd16;
      run_op(k, m, dag_ptr_e'(r1[7:6] % 3), dag_alu_e'(r1[10:8] % 6), d, s, r1[26:21], r2[5:0], da, r2[26:16]);
    end
    op_valid_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    summarize();
  end
endmodule
